// >>> src/bvm_payload_buf.sv
/*
 Hidden payload store behind the write-only window.
 Assumes the caller bounds the write index below the depth.
*/
`timescale 1ns/100ps
`default_nettype none
module bvm_payload_buf (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Write side
    input  wire logic                        wr_en,
    input  wire logic [bvm_pkg::PTR_W-1:0]   wr_idx,
    input  wire logic [7:0]                  wr_byte,
    // Read side
    input  wire logic [bvm_pkg::PTR_W-1:0]   rd_idx,
    output logic      [7:0]                  rd_byte
);
    logic [7:0] mem_ff [bvm_pkg::PAYLOAD_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < bvm_pkg::PAYLOAD_DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem_ff[gi] <= bvm_pkg::RST_PAYLOAD;
                end else if (wr_en && (wr_idx == bvm_pkg::PTR_W'(gi))) begin
                    mem_ff[gi] <= wr_byte;
                end
            end
        end
    endgenerate

    // Out-of-range reads give zero rather than an undefined entry
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_byte <= bvm_pkg::RST_PAYLOAD;
        end else if (rd_idx < bvm_pkg::PTR_W'(bvm_pkg::PAYLOAD_DEPTH)) begin
            rd_byte <= mem_ff[rd_idx];
        end else begin
            rd_byte <= bvm_pkg::RST_PAYLOAD;
        end
    end
endmodule
`default_nettype wire

// >>> src/bvm_pkg.sv
/*
 Constants, states and register map of the bus-voltage monitor register bank.
 Assumes one 100 MHz clock and a byte-wide register port fed by an I2C target front end.
*/
// Overview of operation
// - Window-write bytes after the count byte, up to the count and the 30-entry depth, are stored in a hidden write-only buffer that resets to zero.
// - Register 0x70 reads the low eight bits of the 10-bit bus-voltage reading at 25mV per code and resets to zero.
// - Register 0x71 bits 1:0 read the top two bits of the 10-bit bus-voltage reading.
// - The bus-voltage reading is only valid while the monitor enable is in its enabling state, whose polarity is left open.
// - Register 0x71 bits 3:2 always read 00, meaning the reading is not scaled.
// - The stop-discharge threshold is a read-write 10-bit value, low byte plus two upper bits, resetting to 0x020.
// - Any stop-discharge code from zero up to 0x018 means a fixed 0.5V level.
// - Stop-discharge codes from 0x01C to 0x3FF mean the code times 25mV.
// - The two lowest stop-discharge code bits are ignored, so bit 2 is the step of 100mV.
// - Writing 0 to the alarm control enables the voltage alarms and writing 1 disables them.
// - With alarms enabled and the voltage above the high threshold, the over-voltage flag is set.
// - The over-voltage flag is level triggered and comes back after a clear while the condition persists.
// - The over-voltage threshold is 10 bits at 25mV, low byte at 0x76 and upper bits in 0x77 bits 1:0, resetting to zero.
package bvm_pkg;
    localparam logic [7:0] ADDR_PAYLOAD_WIN = 8'h51;
    localparam logic [7:0] ADDR_VOLT_LO     = 8'h70;
    localparam logic [7:0] ADDR_VOLT_HI     = 8'h71;
    localparam logic [7:0] ADDR_STOP_LO     = 8'h74;
    localparam logic [7:0] ADDR_STOP_HI     = 8'h75;
    localparam logic [7:0] ADDR_OV_LO       = 8'h76;
    localparam logic [7:0] ADDR_OV_HI       = 8'h77;

    localparam logic [9:0] RST_STOP_LEVEL   = 10'h020;
    localparam logic [9:0] RST_OV_LEVEL     = 10'h000;
    localparam logic [9:0] RST_READING      = 10'h000;
    localparam logic [7:0] RST_PAYLOAD      = 8'h00;

    // Stop-discharge decode: codes up to the floor map to 0.5V = 20 codes of 25mV
    localparam logic [9:0] STOP_FLOOR_CODE  = 10'h018;
    localparam logic [9:0] STOP_HALF_VOLT   = 10'h014;
    localparam logic [9:0] STOP_LSB_MASK    = 10'h3FC;

    localparam logic [1:0] SCALE_NONE       = 2'h0;
    localparam int         PAYLOAD_DEPTH    = 30;
    localparam int         PTR_W            = 5;

    typedef enum logic [2:0] {
        WIN_IDLE  = 3'b001,
        WIN_COUNT = 3'b010,
        WIN_DATA  = 3'b100
    } bvm_win_t;
endpackage

// >>> src/bvm_regs.sv
/*
 Bus-voltage monitor register bank: reading, stop-discharge threshold,
 over-voltage alarm and the payload write window.
 Assumes an I2C target front end that presents one byte access per strobe,
 synchronous to CLK.
*/
`timescale 1ns/100ps
`default_nettype none
module bvm_regs #(
    // Level of VOLT_MON_EN that counts as enabled; the polarity is not settled
    parameter logic MON_EN_ACTIVE = 1'b1
) (
    // Clock and reset
    input  wire logic                        CLK,
    input  wire logic                        RST_B,
    // Register byte port
    input  wire logic                        WR_STB,
    input  wire logic                        WR_FIRST,
    input  wire logic                        RD_STB,
    input  wire logic                        TXN_END,
    input  wire logic [7:0]                  ADDR,
    input  wire logic [7:0]                  WDATA,
    output logic      [7:0]                  RDATA,
    output logic                             RD_VALID,
    // ADC and controls
    input  wire logic [9:0]                  ADC_SAMPLE,
    input  wire logic                        ADC_VALID,
    input  wire logic                        VOLT_MON_EN,
    input  wire logic                        VOLT_ALARM_CTRL,
    input  wire logic                        OV_FLAG_CLR,
    // Alarm and threshold
    output logic                             OV_FLAG,
    output logic      [9:0]                  DISCH_STOP_CODE,
    // Payload consumer
    input  wire logic                        TX_BUF_RESET,
    input  wire logic [bvm_pkg::PTR_W-1:0]   PAYLOAD_RD_IDX,
    output logic      [7:0]                  PAYLOAD_BYTE,
    output logic      [bvm_pkg::PTR_W-1:0]   PAYLOAD_LEN
);
    bvm_pkg::bvm_win_t           win_ff;
    bvm_pkg::bvm_win_t           nxt_win;
    logic [9:0]                  reading_ff;
    logic [9:0]                  stop_level_ff;
    logic [9:0]                  ov_level_ff;
    logic                        ov_cond_ff;
    logic [7:0]                  count_ff;
    logic [7:0]                  got_ff;
    logic [bvm_pkg::PTR_W-1:0]   ptr_ff;

    // Decode
    wire mon_on      = (VOLT_MON_EN == MON_EN_ACTIVE);
    wire alarms_on   = ~VOLT_ALARM_CTRL;
    wire wr_win      = WR_STB && (ADDR == bvm_pkg::ADDR_PAYLOAD_WIN);
    wire wr_stop_lo  = WR_STB && (ADDR == bvm_pkg::ADDR_STOP_LO);
    wire wr_stop_hi  = WR_STB && (ADDR == bvm_pkg::ADDR_STOP_HI);
    wire wr_ov_lo    = WR_STB && (ADDR == bvm_pkg::ADDR_OV_LO);
    wire wr_ov_hi    = WR_STB && (ADDR == bvm_pkg::ADDR_OV_HI);
    wire win_count   = wr_win && WR_FIRST;
    wire win_space   = (ptr_ff < bvm_pkg::PTR_W'(bvm_pkg::PAYLOAD_DEPTH));
    // Bytes beyond the announced count or the buffer depth are dropped;
    // a data byte may follow the count byte in the very next cycle
    wire win_store   = wr_win && !WR_FIRST && (win_ff != bvm_pkg::WIN_IDLE)
                       && (got_ff < count_ff) && win_space;
    wire ov_set      = alarms_on && ov_cond_ff;
    wire [9:0] stop_masked = stop_level_ff & bvm_pkg::STOP_LSB_MASK;
    wire [9:0] stop_eff    = (stop_masked <= bvm_pkg::STOP_FLOOR_CODE) ?
                             bvm_pkg::STOP_HALF_VOLT : stop_masked;

    logic [7:0] rd_mux;
    always_comb begin
        case (ADDR)
            bvm_pkg::ADDR_VOLT_LO: rd_mux = reading_ff[7:0];
            bvm_pkg::ADDR_VOLT_HI: rd_mux = {4'h0, bvm_pkg::SCALE_NONE, reading_ff[9:8]};
            bvm_pkg::ADDR_STOP_LO: rd_mux = stop_level_ff[7:0];
            bvm_pkg::ADDR_STOP_HI: rd_mux = {6'h00, stop_level_ff[9:8]};
            bvm_pkg::ADDR_OV_LO:   rd_mux = ov_level_ff[7:0];
            bvm_pkg::ADDR_OV_HI:   rd_mux = {6'h00, ov_level_ff[9:8]};
            default:               rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        case (win_ff)
            bvm_pkg::WIN_IDLE:  nxt_win = win_count ? bvm_pkg::WIN_COUNT : bvm_pkg::WIN_IDLE;
            bvm_pkg::WIN_COUNT: nxt_win = TXN_END ? bvm_pkg::WIN_IDLE : bvm_pkg::WIN_DATA;
            bvm_pkg::WIN_DATA:  nxt_win = TXN_END ? bvm_pkg::WIN_IDLE : bvm_pkg::WIN_DATA;
            default:            nxt_win = bvm_pkg::WIN_IDLE;
        endcase
        if (win_count) begin
            nxt_win = bvm_pkg::WIN_COUNT;
        end
    end

    // Read port
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA    <= 8'h00;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= RD_STB;
            if (RD_STB) begin
                RDATA <= rd_mux;
            end
        end
    end

    // Reading held while the monitor is off, so software never sees a stale-enable sample
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            reading_ff <= bvm_pkg::RST_READING;
        end else if (ADC_VALID && mon_on) begin
            reading_ff <= ADC_SAMPLE;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stop_level_ff <= bvm_pkg::RST_STOP_LEVEL;
            ov_level_ff   <= bvm_pkg::RST_OV_LEVEL;
        end else begin
            if (wr_stop_lo) stop_level_ff[7:0] <= WDATA;
            if (wr_stop_hi) stop_level_ff[9:8] <= WDATA[1:0];
            if (wr_ov_lo)   ov_level_ff[7:0]   <= WDATA;
            if (wr_ov_hi)   ov_level_ff[9:8]   <= WDATA[1:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            DISCH_STOP_CODE <= bvm_pkg::STOP_HALF_VOLT;
        end else begin
            DISCH_STOP_CODE <= stop_eff;
        end
    end

    // Compare is refreshed only on a new sample; with alarms on the held result sets the flag, which holds until OV_FLAG_CLR
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ov_cond_ff <= 1'b0;
            OV_FLAG    <= 1'b0;
        end else begin
            if (ADC_VALID) begin
                ov_cond_ff <= (ADC_SAMPLE > ov_level_ff);
            end
            OV_FLAG <= ov_set | (OV_FLAG & ~OV_FLAG_CLR);
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            win_ff   <= bvm_pkg::WIN_IDLE;
            count_ff <= 8'h00;
            got_ff   <= 8'h00;
            ptr_ff   <= '0;
        end else begin
            win_ff <= nxt_win;
            if (win_count) begin
                count_ff <= WDATA;
                got_ff   <= 8'h00;
            end else if (win_store) begin
                got_ff <= got_ff + 8'h01;
            end
            if (TX_BUF_RESET) begin
                ptr_ff <= '0;
            end else if (win_store) begin
                ptr_ff <= ptr_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PAYLOAD_LEN <= '0;
        end else begin
            PAYLOAD_LEN <= TX_BUF_RESET ? '0 : (win_store ? ptr_ff + 5'h01 : ptr_ff);
        end
    end

    bvm_payload_buf u_buf (
        .clk     (CLK),
        .rst_b   (RST_B),
        .wr_en   (win_store),
        .wr_idx  (ptr_ff),
        .wr_byte (WDATA),
        .rd_idx  (PAYLOAD_RD_IDX),
        .rd_byte (PAYLOAD_BYTE)
    );

    sequence s_ov_cause;
        ADC_VALID && (ADC_SAMPLE > ov_level_ff) ##1 (alarms_on && !ADC_VALID);
    endsequence

    chk_ov_sets: assert property (@(posedge CLK) disable iff (!RST_B)
        s_ov_cause |=> OV_FLAG)
        else $error("over-voltage flag not set after exceeding sample");

    chk_ov_reassert: assert property (@(posedge CLK) disable iff (!RST_B)
        (OV_FLAG_CLR && ov_cond_ff && alarms_on) |=> OV_FLAG)
        else $error("over-voltage flag lost on clear while condition held");

    chk_ov_disabled: assert property (@(posedge CLK) disable iff (!RST_B)
        (!OV_FLAG && VOLT_ALARM_CTRL) |=> !OV_FLAG)
        else $error("over-voltage flag rose with alarms disabled");

    chk_rd_low: assert property (@(posedge CLK) disable iff (!RST_B)
        (RD_STB && ADDR == bvm_pkg::ADDR_VOLT_LO) |=> (RDATA == $past(reading_ff[7:0]) && RD_VALID))
        else $error("low reading byte mismatch");

    chk_rd_high: assert property (@(posedge CLK) disable iff (!RST_B)
        (RD_STB && ADDR == bvm_pkg::ADDR_VOLT_HI) |=> (RDATA == {6'h00, $past(reading_ff[9:8])}))
        else $error("high reading byte or scale field wrong");

    chk_mon_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        !mon_on |=> $stable(reading_ff))
        else $error("reading changed while monitor disabled");

    chk_stop_floor: assert property (@(posedge CLK) disable iff (!RST_B)
        (stop_level_ff <= bvm_pkg::STOP_FLOOR_CODE) ##1 $stable(stop_level_ff)
        |-> (DISCH_STOP_CODE == bvm_pkg::STOP_HALF_VOLT))
        else $error("stop level below floor not clamped to 0.5V");

    chk_stop_lsbs: assert property (@(posedge CLK) disable iff (!RST_B)
        (DISCH_STOP_CODE[1:0] == 2'h0) && (DISCH_STOP_CODE >= bvm_pkg::STOP_HALF_VOLT))
        else $error("stop level low bits not ignored");

    chk_stop_linear: assert property (@(posedge CLK) disable iff (!RST_B)
        (stop_level_ff >= 10'h01C) |=> (DISCH_STOP_CODE == ($past(stop_level_ff) & 10'h3FC)))
        else $error("stop level linear decode wrong");

    chk_count_latch: assert property (@(posedge CLK) disable iff (!RST_B)
        win_count |=> (count_ff == $past(WDATA) && got_ff == 8'h00 && win_ff == bvm_pkg::WIN_COUNT))
        else $error("window count byte not captured");

    chk_payload_cap: assert property (@(posedge CLK) disable iff (!RST_B)
        (win_ff == bvm_pkg::WIN_DATA && got_ff >= count_ff && !TX_BUF_RESET && !win_count)
        |=> $stable(ptr_ff))
        else $error("payload stored past announced count");
endmodule
`default_nettype wire

// >>> tb/bvm_mgr.sv
/*
 Port manager model: drives byte writes and reads onto the register port.
 Assumes the bank samples on rising CLK; this model drives on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module bvm_mgr (
    // Clock
    input  wire logic       clk,
    // Register byte port
    output logic            wr_stb,
    output logic            wr_first,
    output logic            rd_stb,
    output logic            txn_end,
    output logic [7:0]      addr,
    output logic [7:0]      wdata
);
    initial begin
        wr_stb   = 1'b0;
        wr_first = 1'b0;
        rd_stb   = 1'b0;
        txn_end  = 1'b0;
        addr     = 8'h00;
        wdata    = 8'h00;
    end

    // One byte per strobe; first marks the count byte of a window write
    task automatic put(input logic w, input logic f, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_stb   <= w;
        rd_stb   <= !w;
        wr_first <= f;
        addr     <= a;
        wdata    <= d;
        @(negedge clk);
        wr_stb   <= 1'b0;
        rd_stb   <= 1'b0;
        wr_first <= 1'b0;
        // Released lines flip so a stale value never passes for a held one
        addr     <= ~a;
        wdata    <= ~d;
    endtask

    task automatic end_txn();
        @(negedge clk);
        txn_end <= 1'b1;
        @(negedge clk);
        txn_end <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/bvm_regs_tb.sv
/*
 Self-checking bench of the bus-voltage monitor register bank.
 Assumes bvm_mgr as the port manager and default MON_EN_ACTIVE of 1.
*/
`timescale 1ns/100ps
`default_nettype none
module bvm_regs_tb;
    logic       clk, rst_b, wr_stb, wr_first, rd_stb, txn_end, rd_valid, ov_flag;
    logic       adc_vld, mon_en, alm_ctrl, ov_clr, buf_rst;
    logic [7:0] addr, wdata, rdata, pay_byte, b0, b1;
    logic [9:0] adc, stop_code, s;
    logic [4:0] rd_idx, pay_len;
    logic [7:0] exp_q[$];
    logic [9:0] sc[6] = '{10'h000, 10'h018, 10'h01B, 10'h01C, 10'h021, 10'h3FF};
    logic [9:0] se[6] = '{10'h014, 10'h014, 10'h014, 10'h01C, 10'h020, 10'h3FC};
    int         n_mismatch, compares, cyc;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    bvm_mgr mgr (.clk(clk), .wr_stb(wr_stb), .wr_first(wr_first), .rd_stb(rd_stb),
                 .txn_end(txn_end), .addr(addr), .wdata(wdata));

    bvm_regs dut (.CLK(clk), .RST_B(rst_b), .WR_STB(wr_stb), .WR_FIRST(wr_first),
                  .RD_STB(rd_stb), .TXN_END(txn_end), .ADDR(addr), .WDATA(wdata),
                  .RDATA(rdata), .RD_VALID(rd_valid), .ADC_SAMPLE(adc), .ADC_VALID(adc_vld),
                  .VOLT_MON_EN(mon_en), .VOLT_ALARM_CTRL(alm_ctrl), .OV_FLAG_CLR(ov_clr),
                  .OV_FLAG(ov_flag), .DISCH_STOP_CODE(stop_code), .TX_BUF_RESET(buf_rst),
                  .PAYLOAD_RD_IDX(rd_idx), .PAYLOAD_BYTE(pay_byte), .PAYLOAD_LEN(pay_len));

    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        mgr.put(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        mgr.put(1'b0, 1'b0, a, 8'h00);
    endtask

    // High selects the buffer reset, low the flag clear
    task automatic pulse(input logic sel_buf);
        @(negedge clk);
        if (sel_buf)
            buf_rst <= 1'b1;
        else
            ov_clr <= 1'b1;
        @(negedge clk);
        buf_rst <= 1'b0;
        ov_clr  <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic smp(input logic [9:0] v);
        @(negedge clk);
        adc     <= v;
        adc_vld <= 1'b1;
        @(negedge clk);
        adc     <= ~v;
        adc_vld <= 1'b0;
        @(negedge clk);
    endtask

    // Read answers are matched in request order
    always @(negedge clk) begin
        if (rd_valid === 1'b1)
            chk("rdata", {2'h0, rdata}, (exp_q.size() > 0) ? {2'h0, exp_q.pop_front()} : 10'h3FF);
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        {rst_b, adc_vld, alm_ctrl, ov_clr, buf_rst, adc, rd_idx} = '0;
        mon_en = 1'b1;
        void'($urandom(32'h8948));
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk("stop_code", stop_code, 10'h020);
        chk("ov_flag", {9'h0, ov_flag}, 10'h000);
        rd(bvm_pkg::ADDR_VOLT_LO, 8'h00);
        rd(bvm_pkg::ADDR_VOLT_HI, 8'h00);
        rd(bvm_pkg::ADDR_STOP_LO, 8'h20);
        rd(bvm_pkg::ADDR_OV_LO, 8'h00);
        rd(bvm_pkg::ADDR_OV_HI, 8'h00);
        rd(bvm_pkg::ADDR_PAYLOAD_WIN, 8'h00);
        rd(8'hA5, 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            wr(bvm_pkg::ADDR_STOP_LO, sc[i][7:0]);
            wr(bvm_pkg::ADDR_STOP_HI, {6'h3F, sc[i][9:8]});
            repeat (2) @(negedge clk);
            chk("stop_code", stop_code, se[i]);
            rd(bvm_pkg::ADDR_STOP_LO, sc[i][7:0]);
            rd(bvm_pkg::ADDR_STOP_HI, {6'h00, sc[i][9:8]});
        end
        $display("test stop_level done");
        for (int i = 0; i < 4; i++) begin
            s = 10'($urandom);
            smp(s);
            wr(bvm_pkg::ADDR_VOLT_LO, ~s[7:0]);
            rd(bvm_pkg::ADDR_VOLT_LO, s[7:0]);
            rd(bvm_pkg::ADDR_VOLT_HI, {6'h00, s[9:8]});
        end
        mon_en <= 1'b0;
        smp(~s);
        rd(bvm_pkg::ADDR_VOLT_LO, s[7:0]);
        mon_en <= 1'b1;
        $display("test reading done");
        wr(bvm_pkg::ADDR_OV_LO, 8'h00);
        wr(bvm_pkg::ADDR_OV_HI, 8'h01);
        rd(bvm_pkg::ADDR_OV_HI, 8'h01);
        smp(10'h100);
        // The random readings above may have latched the flag; clear it first
        pulse(1'b0);
        chk("ov_flag", {9'h0, ov_flag}, 10'h000);
        smp(10'h101);
        chk("ov_flag", {9'h0, ov_flag}, 10'h001);
        pulse(1'b0);
        chk("ov_flag", {9'h0, ov_flag}, 10'h001);
        alm_ctrl <= 1'b1;
        smp(10'h101);
        pulse(1'b0);
        chk("ov_flag", {9'h0, ov_flag}, 10'h000);
        // Low sample lands before alarms return, else the held compare sets the flag
        smp(10'h0FF);
        alm_ctrl <= 1'b0;
        repeat (2) @(negedge clk);
        chk("ov_flag", {9'h0, ov_flag}, 10'h000);
        $display("test over_voltage done");
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        pulse(1'b1);
        mgr.put(1'b1, 1'b1, bvm_pkg::ADDR_PAYLOAD_WIN, 8'h02);
        wr(bvm_pkg::ADDR_PAYLOAD_WIN, b0);
        wr(bvm_pkg::ADDR_PAYLOAD_WIN, b1);
        wr(bvm_pkg::ADDR_PAYLOAD_WIN, ~b1);
        mgr.end_txn();
        wr(bvm_pkg::ADDR_PAYLOAD_WIN, ~b0);
        repeat (2) @(negedge clk);
        chk("pay_len", {5'h0, pay_len}, 10'h002);
        for (int i = 0; i < 3; i++) begin
            rd_idx <= 5'(i);
            repeat (2) @(negedge clk);
            chk("pay_byte", {2'h0, pay_byte}, (i == 0) ? {2'h0, b0} : (i == 1) ? {2'h0, b1} : 10'h000);
        end
        pulse(1'b1);
        chk("pay_len", {5'h0, pay_len}, 10'h000);
        $display("test payload done");
        repeat (3) @(negedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
